/* core/dmsi_regs.svh */
`ifndef DMSI_REGS_SVH
`define DMSI_REGS_SVH

// Byte offsets of each field inside the cyclic input image (little-endian).
`define DMSI_OFF_ALARM      6
`define DMSI_OFF_FB_POS     8
`define DMSI_OFF_SPEED      12
`define DMSI_OFF_CMD_POS    16
`define DMSI_OFF_TORQUE     20
`define DMSI_OFF_LOAD       22
`define DMSI_OFF_INFO       24
`define DMSI_OFF_RD_ID      30
`define DMSI_OFF_STATUS     32
`define DMSI_OFF_WR_ID      34
`define DMSI_OFF_RD_DATA    36
`define DMSI_OFF_MON0       40
`define DMSI_IMAGE_BYTES    56

// Bit positions inside the read/write status word.
`define DMSI_ST_RD_ERR      7
`define DMSI_ST_WR_END      8
`define DMSI_ST_BUSY        9
`define DMSI_ST_WR_SET_ERR  11
`define DMSI_ST_WR_IF_ERR   12
`define DMSI_ST_NVM_REFUSE  13
`define DMSI_ST_EXEC_FAIL   14
`define DMSI_ST_WR_ERR      15

// Reset values.
`define DMSI_RST_16         16'h0000
`define DMSI_RST_32         32'h0000_0000

// Number of monitor slots and the slot index of the scanner read.
`define DMSI_MON_COUNT      4
`define DMSI_SCAN_SLOT      3'h4

`endif

/* core/dmsi_pkg.sv */
package dmsi_pkg;

	typedef enum logic [0:0] {
		DMSI_RD_IDLE = 1'b0,
		DMSI_RD_WAIT = 1'b1
	} dmsi_rd_state_t;

	typedef enum logic [1:0] {
		DMSI_WR_IDLE = 2'b00,
		DMSI_WR_WAIT = 2'b01,
		DMSI_WR_DONE = 2'b10
	} dmsi_wr_state_t;

	typedef enum logic [2:0] {
		DMSI_WRES_OK    = 3'b000,
		DMSI_WRES_RANGE = 3'b001,
		DMSI_WRES_EXEC  = 3'b010
	} dmsi_wres_t;

endpackage

/* core/dmsi_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmsi_regs.svh"

module dmsi_core #(
	parameter int ID_W = 16,
	parameter int DW   = 32
) (
	input  wire logic            clk,
	input  wire logic            sys_rst,
	input  wire logic [15:0]     alarm_code_in,
	input  wire logic            wrap_enable,
	input  wire logic [DW-1:0]   fb_pos_linear,
	input  wire logic [DW-1:0]   fb_pos_wrapped,
	input  wire logic [DW-1:0]   cmd_pos_linear,
	input  wire logic [DW-1:0]   cmd_pos_wrapped,
	input  wire logic [DW-1:0]   speed_hz_in,
	input  wire logic [15:0]     torque_in,
	input  wire logic [15:0]     load_in,
	input  wire logic [31:0]     info_code_in,
	input  wire logic            internal_busy_flag,
	input  wire logic            user_if_active,
	input  wire logic            nvm_active,
	input  wire logic [ID_W-1:0] read_param_id,
	input  wire logic            write_request,
	input  wire logic [ID_W-1:0] write_param_id,
	input  wire logic [DW-1:0]   write_data,
	input  wire logic [ID_W-1:0] mon_addr_0,
	input  wire logic [ID_W-1:0] mon_addr_1,
	input  wire logic [ID_W-1:0] mon_addr_2,
	input  wire logic [ID_W-1:0] mon_addr_3,
	output logic                 par_rd_req,
	output logic [ID_W-1:0]      par_rd_id,
	input  wire logic            par_rd_ack,
	input  wire logic            par_rd_ok,
	input  wire logic [DW-1:0]   par_rd_data,
	output logic                 par_wr_req,
	output logic [ID_W-1:0]      par_wr_id,
	output logic [DW-1:0]        par_wr_data,
	input  wire logic            par_wr_ack,
	input  wire logic [2:0]      par_wr_result,
	output logic [15:0]          active_alarm_code,
	output logic [DW-1:0]        measured_position,
	output logic [DW-1:0]        measured_speed_hz,
	output logic [DW-1:0]        commanded_position,
	output logic [15:0]          torque_percent,
	output logic [15:0]          load_percent,
	output logic [31:0]          active_info_code,
	output logic [ID_W-1:0]      read_id_echo,
	output logic [15:0]          param_access_status,
	output logic [ID_W-1:0]      write_id_echo,
	output logic [DW-1:0]        param_read_value,
	output logic [DW-1:0]        selectable_monitor_0,
	output logic [DW-1:0]        selectable_monitor_1,
	output logic [DW-1:0]        selectable_monitor_2,
	output logic [DW-1:0]        selectable_monitor_3,
	input  wire logic [5:0]      img_addr,
	output logic [7:0]           img_rdata
);

	// Live monitor copies; all scanner-side and motion inputs share clk.
	logic [15:0]                 next_alarm;
	logic [DW-1:0]               next_fb_pos;
	logic [DW-1:0]               next_cmd_pos;

	always_comb begin
		next_alarm   = alarm_code_in;
		next_fb_pos  = wrap_enable ? fb_pos_wrapped : fb_pos_linear;
		next_cmd_pos = wrap_enable ? cmd_pos_wrapped : cmd_pos_linear;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			active_alarm_code  <= `DMSI_RST_16;
			measured_position  <= '0;
			commanded_position <= '0;
			measured_speed_hz  <= '0;
			torque_percent     <= `DMSI_RST_16;
			load_percent       <= `DMSI_RST_16;
			active_info_code   <= `DMSI_RST_32;
		end else begin
			active_alarm_code  <= next_alarm;
			measured_position  <= next_fb_pos;
			commanded_position <= next_cmd_pos;
			measured_speed_hz  <= speed_hz_in;
			torque_percent     <= torque_in;
			load_percent       <= load_in;
			active_info_code   <= info_code_in;
		end
	end

	// Read port: slots 0..3 refresh the monitors, slot 4 serves the scanner,
	// visited round robin so every field keeps being refreshed.
	dmsi_pkg::dmsi_rd_state_t    rd_state;
	dmsi_pkg::dmsi_rd_state_t    next_rd_state;
	logic [2:0]                  rd_slot;
	logic [2:0]                  next_rd_slot;
	logic                        rd_err;
	logic                        next_rd_err;
	logic [ID_W-1:0]             next_rd_id;
	logic                        next_rd_req;
	logic [ID_W-1:0]             next_rd_echo;
	logic [DW-1:0]               next_rd_value;
	logic [DW-1:0]               mon [`DMSI_MON_COUNT];
	logic [DW-1:0]               next_mon [`DMSI_MON_COUNT];
	logic [ID_W-1:0]             mon_addr [`DMSI_MON_COUNT];

	assign mon_addr[0] = mon_addr_0;
	assign mon_addr[1] = mon_addr_1;
	assign mon_addr[2] = mon_addr_2;
	assign mon_addr[3] = mon_addr_3;

	always_comb begin
		next_rd_state = rd_state;
		next_rd_slot  = rd_slot;
		next_rd_err   = rd_err;
		next_rd_id    = par_rd_id;
		next_rd_req   = 1'b0;
		next_rd_echo  = read_id_echo;
		next_rd_value = param_read_value;
		next_mon      = mon;
		unique case (rd_state)
			dmsi_pkg::DMSI_RD_IDLE: begin
				next_rd_req   = 1'b1;
				next_rd_id    = (rd_slot == `DMSI_SCAN_SLOT) ? read_param_id : mon_addr[rd_slot[1:0]];
				next_rd_state = dmsi_pkg::DMSI_RD_WAIT;
			end
			dmsi_pkg::DMSI_RD_WAIT: begin
				if (par_rd_ack) begin
					if (rd_slot == `DMSI_SCAN_SLOT) begin
						next_rd_echo = par_rd_id;
						next_rd_err  = !par_rd_ok;
						if (par_rd_ok) begin
							next_rd_value = par_rd_data;
						end
						next_rd_slot = 3'h0;
					end else begin
						if (par_rd_ok) begin
							next_mon[rd_slot[1:0]] = par_rd_data;
						end
						next_rd_slot = rd_slot + 3'h1;
					end
					next_rd_state = dmsi_pkg::DMSI_RD_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_state         <= dmsi_pkg::DMSI_RD_IDLE;
			rd_slot          <= `DMSI_SCAN_SLOT;
			rd_err           <= 1'b0;
			par_rd_id        <= '0;
			par_rd_req       <= 1'b0;
			read_id_echo     <= '0;
			param_read_value <= '0;
			for (int i = 0; i < `DMSI_MON_COUNT; i++) begin
				mon[i] <= '0;
			end
		end else begin
			rd_state         <= next_rd_state;
			rd_slot          <= next_rd_slot;
			rd_err           <= next_rd_err;
			par_rd_id        <= next_rd_id;
			par_rd_req       <= next_rd_req;
			read_id_echo     <= next_rd_echo;
			param_read_value <= next_rd_value;
			mon              <= next_mon;
		end
	end

	assign selectable_monitor_0 = mon[0];
	assign selectable_monitor_1 = mon[1];
	assign selectable_monitor_2 = mon[2];
	assign selectable_monitor_3 = mon[3];

	// Write handshake. Detail error bits stay until the next write starts so
	// the scanner can still read the cause after withdrawing its request.
	dmsi_pkg::dmsi_wr_state_t    wr_state;
	dmsi_pkg::dmsi_wr_state_t    next_wr_state;
	logic                        wr_done;
	logic                        next_wr_done;
	logic                        wr_set_err;
	logic                        next_wr_set_err;
	logic                        wr_if_err;
	logic                        next_wr_if_err;
	logic                        write_nvm_conflict;
	logic                        next_write_nvm_conflict;
	logic                        command_exec_fail;
	logic                        next_command_exec_fail;
	logic                        wr_err;
	logic                        next_wr_err;
	logic                        next_wr_req;
	logic [ID_W-1:0]             next_wr_id;
	logic [DW-1:0]               next_wr_data;

	always_comb begin
		next_wr_state   = wr_state;
		next_wr_done    = wr_done;
		next_wr_set_err = wr_set_err;
		next_wr_if_err  = wr_if_err;
		next_write_nvm_conflict = write_nvm_conflict;
		next_command_exec_fail  = command_exec_fail;
		next_wr_err     = wr_err;
		next_wr_req     = 1'b0;
		next_wr_id      = par_wr_id;
		next_wr_data    = par_wr_data;
		unique case (wr_state)
			dmsi_pkg::DMSI_WR_IDLE: begin
				if (write_request) begin
					next_wr_id      = write_param_id;
					next_wr_data    = write_data;
					next_wr_set_err = 1'b0;
					next_wr_if_err  = 1'b0;
					next_write_nvm_conflict = 1'b0;
					next_command_exec_fail  = 1'b0;
					next_wr_err     = 1'b0;
					if (user_if_active) begin
						next_wr_if_err = 1'b1;
						next_wr_err    = 1'b1;
						next_wr_done   = 1'b1;
						next_wr_state  = dmsi_pkg::DMSI_WR_DONE;
					end else if (nvm_active) begin
						next_write_nvm_conflict = 1'b1;
						next_wr_err    = 1'b1;
						next_wr_done   = 1'b1;
						next_wr_state  = dmsi_pkg::DMSI_WR_DONE;
					end else begin
						next_wr_req   = 1'b1;
						next_wr_state = dmsi_pkg::DMSI_WR_WAIT;
					end
				end
			end
			dmsi_pkg::DMSI_WR_WAIT: begin
				if (par_wr_ack) begin
					case (par_wr_result)
						dmsi_pkg::DMSI_WRES_OK: next_wr_err = 1'b0;
						dmsi_pkg::DMSI_WRES_RANGE: begin
							next_wr_set_err = 1'b1;
							next_wr_err     = 1'b1;
						end
						default: begin
							next_command_exec_fail = 1'b1;
							next_wr_err     = 1'b1;
						end
					endcase
					next_wr_done  = 1'b1;
					next_wr_state = dmsi_pkg::DMSI_WR_DONE;
				end
			end
			dmsi_pkg::DMSI_WR_DONE: begin
				if (!write_request) begin
					next_wr_done  = 1'b0;
					next_wr_err   = 1'b0;
					next_wr_state = dmsi_pkg::DMSI_WR_IDLE;
				end
			end
			default: next_wr_state = dmsi_pkg::DMSI_WR_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_state           <= dmsi_pkg::DMSI_WR_IDLE;
			wr_done            <= 1'b0;
			wr_set_err         <= 1'b0;
			wr_if_err          <= 1'b0;
			write_nvm_conflict <= 1'b0;
			command_exec_fail  <= 1'b0;
			wr_err             <= 1'b0;
			par_wr_req         <= 1'b0;
			par_wr_id          <= '0;
			par_wr_data        <= '0;
			write_id_echo      <= '0;
		end else begin
			wr_state           <= next_wr_state;
			wr_done            <= next_wr_done;
			wr_set_err         <= next_wr_set_err;
			wr_if_err          <= next_wr_if_err;
			write_nvm_conflict <= next_write_nvm_conflict;
			command_exec_fail  <= next_command_exec_fail;
			wr_err             <= next_wr_err;
			par_wr_req         <= next_wr_req;
			par_wr_id          <= next_wr_id;
			par_wr_data        <= next_wr_data;
			write_id_echo      <= next_wr_id;
		end
	end

	// Status word, reserved bits forced to zero.
	logic [15:0]                 next_status;

	always_comb begin
		next_status                       = `DMSI_RST_16;
		next_status[`DMSI_ST_RD_ERR]      = rd_err;
		next_status[`DMSI_ST_WR_END]      = wr_done;
		next_status[`DMSI_ST_BUSY]        = internal_busy_flag | (wr_state == dmsi_pkg::DMSI_WR_WAIT);
		next_status[`DMSI_ST_WR_SET_ERR]  = wr_set_err;
		next_status[`DMSI_ST_WR_IF_ERR]   = wr_if_err;
		next_status[`DMSI_ST_NVM_REFUSE]  = write_nvm_conflict;
		next_status[`DMSI_ST_EXEC_FAIL]   = command_exec_fail;
		next_status[`DMSI_ST_WR_ERR]      = wr_err;
	end

	// Byte view of the cyclic image; unmapped and reserved bytes read zero.
	logic [`DMSI_IMAGE_BYTES*8-1:0] image;
	logic [7:0]                  next_img;

	always_comb begin
		image = '0;
		image[`DMSI_OFF_ALARM*8 +: 16]    = active_alarm_code;
		image[`DMSI_OFF_FB_POS*8 +: 32]   = measured_position;
		image[`DMSI_OFF_SPEED*8 +: 32]    = measured_speed_hz;
		image[`DMSI_OFF_CMD_POS*8 +: 32]  = commanded_position;
		image[`DMSI_OFF_TORQUE*8 +: 16]   = torque_percent;
		image[`DMSI_OFF_LOAD*8 +: 16]     = load_percent;
		image[`DMSI_OFF_INFO*8 +: 32]     = active_info_code;
		image[`DMSI_OFF_RD_ID*8 +: 16]    = read_id_echo;
		image[`DMSI_OFF_STATUS*8 +: 16]   = param_access_status;
		image[`DMSI_OFF_WR_ID*8 +: 16]    = write_id_echo;
		image[`DMSI_OFF_RD_DATA*8 +: 32]  = param_read_value;
		for (int i = 0; i < `DMSI_MON_COUNT; i++) begin
			image[(`DMSI_OFF_MON0 + 4*i)*8 +: 32] = mon[i];
		end
		next_img = (int'(img_addr) < `DMSI_IMAGE_BYTES) ? image[img_addr*8 +: 8] : 8'h00;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			param_access_status <= `DMSI_RST_16;
			img_rdata           <= 8'h00;
		end else begin
			param_access_status <= next_status;
			img_rdata           <= next_img;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_rd_err_set: assert property (rd_state == dmsi_pkg::DMSI_RD_WAIT && par_rd_ack && !par_rd_ok
		&& rd_slot == `DMSI_SCAN_SLOT |=> ##1 param_access_status[7]) else $error("read error not flagged");
	a_rd_err_clr: assert property (rd_state == dmsi_pkg::DMSI_RD_WAIT && par_rd_ack && par_rd_ok
		&& rd_slot == `DMSI_SCAN_SLOT |=> ##1 !param_access_status[7]) else $error("read error not cleared");
	a_wr_end_hold: assert property (wr_done && write_request |=> wr_done) else $error("write end dropped");
	a_wr_end_drop: assert property (wr_state == dmsi_pkg::DMSI_WR_DONE && !write_request
		|=> ##1 !param_access_status[8] && !param_access_status[15]) else $error("end or error kept");
	a_wr_sum_err: assert property (param_access_status[15] |-> |param_access_status[14:11])
		else $error("summary error without cause");
	a_wr_if_refuse: assert property (wr_state == dmsi_pkg::DMSI_WR_IDLE && write_request && user_if_active
		|=> wr_if_err && !par_wr_req ##1 param_access_status[12]) else $error("busy interface write not refused");
	a_wr_nv_refuse: assert property (wr_state == dmsi_pkg::DMSI_WR_IDLE && write_request && !user_if_active
		&& nvm_active |=> write_nvm_conflict && !par_wr_req) else $error("nvm write not refused");
	a_wr_range_err: assert property (wr_state == dmsi_pkg::DMSI_WR_WAIT && par_wr_ack
		&& par_wr_result == dmsi_pkg::DMSI_WRES_RANGE |=> ##1 param_access_status[11] && param_access_status[8])
		else $error("range error not flagged");
	a_busy_flag: assert property (internal_busy_flag |=> param_access_status[9]) else $error("busy not shown");
	a_rsvd_zero: assert property (param_access_status[6:0] == 7'h00 && !param_access_status[10])
		else $error("reserved status bit set");
	a_pos_wrap: assert property (wrap_enable |=> measured_position == $past(fb_pos_wrapped)
		&& commanded_position == $past(cmd_pos_wrapped)) else $error("wrapped position not used");

	c_wr_ok: cover property (wr_state == dmsi_pkg::DMSI_WR_WAIT && par_wr_ack
		&& par_wr_result == dmsi_pkg::DMSI_WRES_OK);
	c_wr_refused: cover property (wr_state == dmsi_pkg::DMSI_WR_IDLE && write_request && user_if_active);
	c_rd_fail: cover property (par_rd_ack && !par_rd_ok && rd_slot == `DMSI_SCAN_SLOT);
	c_mon_update: cover property (par_rd_ack && par_rd_ok && rd_slot == 3'h3);

endmodule

`default_nettype wire

/* tb/dmsi_param_store.sv */
`timescale 1ns/1ps
`default_nettype none

module dmsi_param_store (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        slow,
	input  wire logic        rd_req,
	input  wire logic [15:0] rd_id,
	output logic             rd_ack,
	output logic             rd_ok,
	output logic [31:0]      rd_data,
	input  wire logic        wr_req,
	input  wire logic [15:0] wr_id,
	input  wire logic [31:0] wr_data,
	output logic             wr_ack,
	output logic [2:0]       wr_result
);
	logic                 rd_pend;
	logic                 wr_pend;
	logic [2:0]           rd_cnt;
	logic [2:0]           wr_cnt;
	logic [15:0]          rd_id_q;
	logic [15:0]          wr_id_q;
	logic [31:0]          value;
	dmsi_pkg::dmsi_wres_t res;

	// Contents follow a fixed pattern; identifiers with the top bit set do not exist.
	assign value = {rd_id_q ^ 16'h5a5a, rd_id_q};
	// Between answers the lines carry the inverse, so stale data cannot pass for fresh.
	assign rd_data = rd_ack ? value : ~value;
	assign rd_ok = rd_ack ? !rd_id_q[15] : rd_id_q[15];
	assign res = wr_id_q[15] ? dmsi_pkg::DMSI_WRES_RANGE
		: (wr_id_q[14] ? dmsi_pkg::DMSI_WRES_EXEC : dmsi_pkg::DMSI_WRES_OK);
	assign wr_result = wr_ack ? res : 3'h7;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_ack <= 1'b0;
			rd_pend <= 1'b0;
			rd_cnt <= 3'h0;
			rd_id_q <= 16'h0000;
			wr_ack <= 1'b0;
			wr_pend <= 1'b0;
			wr_cnt <= 3'h0;
			wr_id_q <= 16'h0000;
		end else begin
			rd_ack <= 1'b0;
			wr_ack <= 1'b0;
			if (rd_req) begin
				rd_pend <= 1'b1;
				rd_id_q <= rd_id;
				rd_cnt <= slow ? 3'h4 : 3'h0;
			end else if (rd_pend && rd_cnt == 3'h0) begin
				rd_ack <= 1'b1;
				rd_pend <= 1'b0;
			end else if (rd_pend) begin
				rd_cnt <= rd_cnt - 3'h1;
			end
			if (wr_req) begin
				wr_pend <= 1'b1;
				wr_id_q <= wr_id;
				wr_cnt <= slow ? 3'h5 : 3'h1;
			end else if (wr_pend && wr_cnt == 3'h0) begin
				wr_ack <= 1'b1;
				wr_pend <= 1'b0;
			end else if (wr_pend) begin
				wr_cnt <= wr_cnt - 3'h1;
			end
		end
	end
endmodule

`default_nettype wire

/* tb/drive_monitor_status_image_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module drive_monitor_status_image_tb;
	logic        clk, sys_rst, wrap, busy, uif, nvm, wreq, slow;
	logic [15:0] alarm, trq, load, rid, wid, ma0, ma1, ma2, ma3;
	logic [31:0] fbl, fbw, cml, cmw, spd, info, wdat;
	logic [5:0]  img_addr;
	logic        prq, pack, pok, pwq, pwack;
	logic [15:0] prid, pwid, alm_o, trq_o, ld_o, rid_e, st, wid_e;
	logic [31:0] pdat, pwdat, mpos, mspd, cpos, info_o, rval, m0, m1, m2, m3;
	logic [2:0]  pwres;
	logic [7:0]  img_rdata;
	int          fails, comparisons;

	dmsi_core dmsi_core_inst (.clk(clk), .sys_rst(sys_rst), .alarm_code_in(alarm), .wrap_enable(wrap),
		.fb_pos_linear(fbl), .fb_pos_wrapped(fbw), .cmd_pos_linear(cml), .cmd_pos_wrapped(cmw),
		.speed_hz_in(spd), .torque_in(trq), .load_in(load), .info_code_in(info), .internal_busy_flag(busy),
		.user_if_active(uif), .nvm_active(nvm), .read_param_id(rid), .write_request(wreq),
		.write_param_id(wid), .write_data(wdat), .mon_addr_0(ma0), .mon_addr_1(ma1), .mon_addr_2(ma2),
		.mon_addr_3(ma3), .par_rd_req(prq), .par_rd_id(prid), .par_rd_ack(pack), .par_rd_ok(pok),
		.par_rd_data(pdat), .par_wr_req(pwq), .par_wr_id(pwid), .par_wr_data(pwdat), .par_wr_ack(pwack),
		.par_wr_result(pwres), .active_alarm_code(alm_o), .measured_position(mpos),
		.measured_speed_hz(mspd), .commanded_position(cpos), .torque_percent(trq_o), .load_percent(ld_o),
		.active_info_code(info_o), .read_id_echo(rid_e), .param_access_status(st), .write_id_echo(wid_e),
		.param_read_value(rval), .selectable_monitor_0(m0), .selectable_monitor_1(m1),
		.selectable_monitor_2(m2), .selectable_monitor_3(m3), .img_addr(img_addr), .img_rdata(img_rdata));

	dmsi_param_store dmsi_param_store_inst (.clk(clk), .sys_rst(sys_rst), .slow(slow), .rd_req(prq),
		.rd_id(prid), .rd_ack(pack), .rd_ok(pok), .rd_data(pdat), .wr_req(pwq), .wr_id(pwid),
		.wr_data(pwdat), .wr_ack(pwack), .wr_result(pwres));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	function automatic logic [31:0] pval(input logic [15:0] id);
		return {id ^ 16'h5a5a, id};
	endfunction

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(inout int n);
		@(negedge clk);
		n++;
		if (n > 300) begin
			fails++;
			$display("unexpected wait length: expected at most 300, seen %0d", n);
			end_of_test();
		end
	endtask

	task automatic s_reset();
		repeat (3) @(negedge clk);
		check("status in reset", {16'h0000, st}, 32'h0000_0000);
		check("position in reset", mpos, 32'h0000_0000);
	endtask

	task automatic s_live();
		alarm = 16'h1234;
		fbl = 32'h1111_2222;
		fbw = 32'h0000_0222;
		cml = 32'h3333_4444;
		cmw = 32'h0000_0444;
		spd = 32'h0001_86a0;
		trq = 16'h03e8;
		load = 16'h8765;
		info = 32'h0000_0040;
		repeat (3) @(negedge clk);
		check("alarm", alm_o, alarm);
		check("feedback position", mpos, fbl);
		check("command position", cpos, cml);
		check("speed", mspd, spd);
		check("torque", trq_o, trq);
		check("load", ld_o, load);
		check("information", info_o, info);
		wrap = 1'b1;
		repeat (3) @(negedge clk);
		check("wrapped feedback position", mpos, fbw);
		check("wrapped command position", cpos, cmw);
		img_addr = 6'h14;
		@(negedge clk);
		check("image torque low", img_rdata, trq[7:0]);
		img_addr = 6'h15;
		@(negedge clk);
		check("image torque high", img_rdata, trq[15:8]);
		img_addr = 6'h3c;
		@(negedge clk);
		check("image past end", img_rdata, 8'h00);
	endtask

	task automatic s_read();
		int n;
		n = 0;
		rid = 16'h0123;
		while (rid_e !== 16'h0123) tick(n);
		check("read value", rval, pval(16'h0123));
		repeat (2) @(negedge clk);
		check("read error clear", st[7], 1'b0);
		slow = 1'b1;
		rid = 16'h8042;
		while (st[7] !== 1'b1) tick(n);
		check("reserved bits", st & 16'h047f, 16'h0000);
		rid = 16'h0200;
		while (st[7] !== 1'b0) tick(n);
		check("read echo", rid_e, 16'h0200);
		check("read value after error", rval, pval(16'h0200));
		slow = 1'b0;
	endtask

	task automatic s_monitors();
		int n;
		n = 0;
		ma0 = 16'h0011;
		ma1 = 16'h0022;
		ma2 = 16'h0033;
		ma3 = 16'h0044;
		while ({m0, m1, m2, m3} !== {pval(ma0), pval(ma1), pval(ma2), pval(ma3)}) tick(n);
		check("monitor 0", m0, pval(16'h0011));
		check("monitor 1", m1, pval(16'h0022));
		check("monitor 2", m2, pval(16'h0033));
		check("monitor 3", m3, pval(16'h0044));
		ma2 = 16'h8033;
		repeat (60) @(negedge clk);
		check("monitor 2 after failed read", m2, pval(16'h0033));
		ma2 = 16'h0033;
	endtask

	task automatic write_cycle(input logic [15:0] id, input logic [15:0] exp_st);
		int n;
		n = 0;
		wid = id;
		wdat = {id, 16'hc0de};
		wreq = 1'b1;
		while (st[8] !== 1'b1) tick(n);
		check("write status", st & 16'hf900, exp_st);
		check("write id echo", wid_e, id);
		repeat (4) @(negedge clk);
		check("write complete held", st[8], 1'b1);
		wreq = 1'b0;
		while (st[8] !== 1'b0) tick(n);
		check("error summary after withdraw", st[15], 1'b0);
		check("reserved bits", st & 16'h047f, 16'h0000);
	endtask

	task automatic s_writes();
		write_cycle(16'h0010, 16'h0100);
		write_cycle(16'h8010, 16'h8900);
		slow = 1'b1;
		write_cycle(16'h4010, 16'hc100);
		slow = 1'b0;
		uif = 1'b1;
		nvm = 1'b1;
		write_cycle(16'h0020, 16'h9100);
		uif = 1'b0;
		write_cycle(16'h0030, 16'ha100);
		nvm = 1'b0;
		write_cycle(16'h0040, 16'h0100);
	endtask

	task automatic s_busy();
		busy = 1'b1;
		repeat (3) @(negedge clk);
		check("busy set", st[9], 1'b1);
		busy = 1'b0;
		repeat (3) @(negedge clk);
		check("busy clear", st[9], 1'b0);
	endtask

	initial begin
		fails = 0;
		comparisons = 0;
		{sys_rst, wrap, busy, uif, nvm, wreq, slow} = 7'h40;
		{alarm, trq, load, rid, wid, ma0, ma1, ma2, ma3} = '0;
		{fbl, fbw, cml, cmw, spd, info, wdat} = '0;
		img_addr = 6'h00;
		s_reset();
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		s_live();
		s_read();
		s_monitors();
		s_writes();
		s_busy();
		end_of_test();
	end
endmodule

`default_nettype wire
